// >>> design/deadband_chopper_params.svh
// Register map, field positions, reset values and timing counts
`ifndef DEADBAND_CHOPPER_PARAMS_SVH
`define DEADBAND_CHOPPER_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_DEADTIME_CONTROL 6'h0f
`define IDX_RISE_DELAY_COUNT 6'h10
`define IDX_FALL_DELAY_COUNT 6'h11
`define IDX_CHOPPER_CONTROL  6'h1e
`define IDX_TICK_DIVIDER     6'h20
`define IDX_PATH_STATUS      6'h21

// deadtime_control fields
`define DT_OUT_MODE          1:0
`define DT_INVERSION_SELECT  3:2
`define DT_IN_MODE           5:4
`define DT_HALF_CYCLE        15
`define DT_WRITE_MASK        16'h803f

// chopper_control fields
`define CH_ENABLE            0
`define CH_FIRST_PULSE_WIDTH 4:1
`define CH_CARRIER_FREQUENCY 7:5
`define CH_CARRIER_DUTY      10:8
`define CH_WRITE_MASK        16'h07ff

// Reset values
`define RST_DEADTIME_CONTROL 16'h0000
`define RST_DELAY_COUNT      10'h000
`define RST_CHOPPER_CONTROL  16'h0000
`define RST_TICK_DIVIDER     8'h00

// Timing counts in system clocks
`define FIRST_PULSE_UNIT     8
`define CARRIER_STEPS        8

// Bus responses
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10

`endif

// >>> design/deadband_chopper_path.sv
// Dead-band and chopper output path of a PWM channel pair
//
// Functional notes
// - Half-cycle mode steps delays at twice tick when the divider is nonzero
// - Output mode picks which delays apply
// - Mode zero passes inputs, ignores polarity
// - Mode 01: A direct, B falling-delayed A
// - Mode 10: A rising-delayed, B direct
// - Inversion select flips each delayed signal
// - Both delays: polarity gives four pair modes
// - All source, mode, polarity combinations work
// - Delay counts are ten bits of ticks
// - Separate rise and fall delays, own edges
// - Chopper modulates dead-band output with carrier
// - Carrier from system clock, frequency, duty fields
// - Wide first pulse, then carrier-gated pulses
// - First pulse eight clocks times width plus one
// - Chopper disabled passes dead-band outputs unchanged
// - Inputs are upstream channel A and B
// - Input mode selects each delay source
// - Eight duty steps, 12.5% to 100%
`timescale 1ns/1ps
`include "deadband_chopper_params.svh"
module deadband_chopper_path
  import deadband_chopper_pkg::*;
#(
  parameter int DELAY_W = 10,
  parameter int DIV_W   = 8
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output deadband_chopper_pkg::axi_resp_t bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output deadband_chopper_pkg::axi_resp_t rresp,
  input  wire logic        channel_a_in,
  input  wire logic        channel_b_in,
  output logic             channel_a_out,
  output logic             channel_b_out
);
  import deadband_chopper_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic reg_index_t addr_index(input logic [7:0] addr);
    addr_index = addr[7:2];
  endfunction

  function automatic logic is_mapped(input reg_index_t idx);
    is_mapped = (idx == `IDX_DEADTIME_CONTROL) || (idx == `IDX_RISE_DELAY_COUNT) ||
                (idx == `IDX_FALL_DELAY_COUNT) || (idx == `IDX_CHOPPER_CONTROL) ||
                (idx == `IDX_TICK_DIVIDER)     || (idx == `IDX_PATH_STATUS);
  endfunction

  function automatic reg_word_t merge_bytes(input reg_word_t old_val,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
    merge_bytes = old_val;
    if (strb[0]) merge_bytes[7:0]  = data[7:0];
    if (strb[1]) merge_bytes[15:8] = data[15:8];
  endfunction

  // ---------------------------------------------------------------
  // Registers and bus state
  // ---------------------------------------------------------------
  reg_word_t           deadtime_control_reg;
  logic [DELAY_W-1:0]  rise_delay_count_reg;
  logic [DELAY_W-1:0]  fall_delay_count_reg;
  reg_word_t           chopper_control_reg;
  logic [DIV_W-1:0]    tick_divider_reg;
  logic                aw_held_reg;
  logic                w_held_reg;
  logic [7:0]          awaddr_reg;
  logic [31:0]         wdata_reg;
  logic [3:0]          wstrb_reg;
  logic                do_write;
  reg_index_t          wr_idx;
  reg_index_t          rd_idx;
  logic [31:0]         rd_value;

  // Path state
  logic [DIV_W-1:0]    tb_cnt_reg;
  logic                tick;
  logic                delay_step;
  logic                a_q_reg;
  logic                b_q_reg;
  logic                rise_src;
  logic                fall_src;
  logic                rise_delay;
  logic                fall_delay;
  logic [1:0]          out_mode;
  logic [1:0]          inversion_select;
  logic [1:0]          in_mode;
  logic [1:0]          db_out;
  logic [1:0]          db_prev_reg;
  logic [2:0]          carrier_div_reg;
  logic [2:0]          carrier_step_reg;
  logic                carrier;
  logic [7:0]          first_pulse_cnt_reg [2];
  logic [1:0]          first_pulse_on;
  logic [7:0]          first_pulse_len;
  logic [1:0]          chop_out;

  assign do_write = aw_held_reg && w_held_reg && !bvalid;
  assign wr_idx   = addr_index(awaddr_reg);
  assign rd_idx   = addr_index(araddr);

  // ---------------------------------------------------------------
  // Write address and data capture, in either order
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      awready     <= 1'b0;
      awaddr_reg  <= 8'h00;
    end else if (awvalid && awready) begin
      aw_held_reg <= 1'b1;
      awready     <= 1'b0;
      awaddr_reg  <= awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end else if (!aw_held_reg) begin
      awready     <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_held_reg <= 1'b0;
      wready     <= 1'b0;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end else if (wvalid && wready) begin
      w_held_reg <= 1'b1;
      wready     <= 1'b0;
      wdata_reg  <= wdata;
      wstrb_reg  <= wstrb;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end else if (!w_held_reg) begin
      wready     <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Write response
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp  <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= is_mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Register file; status register is read-only
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      deadtime_control_reg <= `RST_DEADTIME_CONTROL;
      rise_delay_count_reg <= `RST_DELAY_COUNT;
      fall_delay_count_reg <= `RST_DELAY_COUNT;
      chopper_control_reg  <= `RST_CHOPPER_CONTROL;
      tick_divider_reg     <= `RST_TICK_DIVIDER;
    end else if (do_write) begin
      case (wr_idx)
        `IDX_DEADTIME_CONTROL:
          deadtime_control_reg <= merge_bytes(deadtime_control_reg, wdata_reg, wstrb_reg)
                                  & `DT_WRITE_MASK;
        `IDX_RISE_DELAY_COUNT:
          rise_delay_count_reg <= DELAY_W'(merge_bytes(16'(rise_delay_count_reg),
                                                       wdata_reg, wstrb_reg));
        `IDX_FALL_DELAY_COUNT:
          fall_delay_count_reg <= DELAY_W'(merge_bytes(16'(fall_delay_count_reg),
                                                       wdata_reg, wstrb_reg));
        `IDX_CHOPPER_CONTROL:
          chopper_control_reg  <= merge_bytes(chopper_control_reg, wdata_reg, wstrb_reg)
                                  & `CH_WRITE_MASK;
        `IDX_TICK_DIVIDER:
          tick_divider_reg     <= DIV_W'(merge_bytes(16'(tick_divider_reg),
                                                     wdata_reg, wstrb_reg));
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  always_comb begin
    rd_value = 32'h0000_0000;
    case (rd_idx)
      `IDX_DEADTIME_CONTROL: rd_value = {16'h0000, deadtime_control_reg};
      `IDX_RISE_DELAY_COUNT: rd_value = 32'(rise_delay_count_reg);
      `IDX_FALL_DELAY_COUNT: rd_value = 32'(fall_delay_count_reg);
      `IDX_CHOPPER_CONTROL:  rd_value = {16'h0000, chopper_control_reg};
      `IDX_TICK_DIVIDER:     rd_value = 32'(tick_divider_reg);
      `IDX_PATH_STATUS:      rd_value = {25'h0, carrier, first_pulse_on, db_prev_reg,
                                         channel_b_out, channel_a_out};
      default:               rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_value;
      rresp   <= is_mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid) begin
      if (rready) begin
        rvalid <= 1'b0;
      end
    end else begin
      arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Time-base tick and delay step
  // ---------------------------------------------------------------
  assign tick = (tb_cnt_reg == tick_divider_reg);
  assign delay_step = tick || (deadtime_control_reg[`DT_HALF_CYCLE] &&
                               tick_divider_reg != '0 &&
                               tb_cnt_reg == (tick_divider_reg >> 1));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tb_cnt_reg <= '0;
    end else if (tick) begin
      tb_cnt_reg <= '0;
    end else begin
      tb_cnt_reg <= tb_cnt_reg + DIV_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // Dead-band stage
  // ---------------------------------------------------------------
  assign out_mode         = deadtime_control_reg[`DT_OUT_MODE];
  assign inversion_select = deadtime_control_reg[`DT_INVERSION_SELECT];
  assign in_mode          = deadtime_control_reg[`DT_IN_MODE];
  assign rise_src = in_mode[0] ? channel_b_in : channel_a_in;
  assign fall_src = in_mode[1] ? channel_b_in : channel_a_in;

  // Align the undelayed path with the delay units' register stage
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      a_q_reg <= 1'b0;
      b_q_reg <= 1'b0;
    end else begin
      a_q_reg <= channel_a_in;
      b_q_reg <= channel_b_in;
    end
  end

  edge_delay #(.WIDTH(DELAY_W)) u_rise_delay (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .kind        (DELAY_RISING_EDGE),
    .sig_in      (rise_src),
    .delay_count (rise_delay_count_reg),
    .step        (delay_step),
    .sig_out     (rise_delay)
  );

  edge_delay #(.WIDTH(DELAY_W)) u_fall_delay (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .kind        (DELAY_FALLING_EDGE),
    .sig_in      (fall_src),
    .delay_count (fall_delay_count_reg),
    .step        (delay_step),
    .sig_out     (fall_delay)
  );

  // Inversion applies after the delay; mode zero ignores it
  assign db_out[0] = out_mode[1] ? (rise_delay ^ inversion_select[0]) : a_q_reg;
  assign db_out[1] = out_mode[0] ? (fall_delay ^ inversion_select[1]) : b_q_reg;

  // ---------------------------------------------------------------
  // Chopper carrier: period 8*(freq+1) clocks, high (duty+1)/8
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      carrier_div_reg  <= 3'h0;
      carrier_step_reg <= 3'h0;
    end else if (carrier_div_reg == chopper_control_reg[`CH_CARRIER_FREQUENCY]) begin
      carrier_div_reg  <= 3'h0;
      carrier_step_reg <= carrier_step_reg + 3'h1;
    end else begin
      carrier_div_reg  <= carrier_div_reg + 3'h1;
    end
  end

  assign carrier = (carrier_step_reg <= chopper_control_reg[`CH_CARRIER_DUTY]);

  // ---------------------------------------------------------------
  // First pulse and output gating, same settings on both channels
  // ---------------------------------------------------------------
  assign first_pulse_len = 8'((chopper_control_reg[`CH_FIRST_PULSE_WIDTH] + 5'h01)
                              * `FIRST_PULSE_UNIT);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      db_prev_reg            <= 2'b00;
      first_pulse_cnt_reg[0] <= 8'h00;
      first_pulse_cnt_reg[1] <= 8'h00;
    end else begin
      db_prev_reg <= db_out;
      for (int ch = 0; ch < 2; ch++) begin
        if (db_out[ch] && !db_prev_reg[ch]) begin
          first_pulse_cnt_reg[ch] <= first_pulse_len - 8'h01;
        end else if (!db_out[ch]) begin
          first_pulse_cnt_reg[ch] <= 8'h00;
        end else if (first_pulse_cnt_reg[ch] != 8'h00) begin
          first_pulse_cnt_reg[ch] <= first_pulse_cnt_reg[ch] - 8'h01;
        end
      end
    end
  end

  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      first_pulse_on[ch] = (db_out[ch] && !db_prev_reg[ch]) ||
                           (first_pulse_cnt_reg[ch] != 8'h00);
      chop_out[ch] = db_out[ch] && (first_pulse_on[ch] || carrier);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_a_out <= 1'b0;
      channel_b_out <= 1'b0;
    end else if (chopper_control_reg[`CH_ENABLE]) begin
      channel_a_out <= chop_out[0];
      channel_b_out <= chop_out[1];
    end else begin
      channel_a_out <= db_out[0];
      channel_b_out <= db_out[1];
    end
  end
endmodule

// >>> design/deadband_chopper_pkg.sv
// Types shared by the dead-band and chopper path
package deadband_chopper_pkg;
  typedef logic [1:0]  axi_resp_t;
  typedef logic [5:0]  reg_index_t;
  typedef logic [9:0]  delay_count_t;
  typedef logic [15:0] reg_word_t;
  typedef enum logic { DELAY_FALLING_EDGE, DELAY_RISING_EDGE } delay_kind_e;
endpackage

// >>> design/edge_delay.sv
// One edge-delay unit: delays one edge kind, passes the other at once
`timescale 1ns/1ps
`include "deadband_chopper_params.svh"
module edge_delay
  import deadband_chopper_pkg::*;
#(
  parameter int WIDTH = 10
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire deadband_chopper_pkg::delay_kind_e kind,
  input  wire logic                 sig_in,
  input  wire logic [WIDTH-1:0]     delay_count,
  input  wire logic                 step,
  output logic                      sig_out
);
  logic [WIDTH-1:0] cnt_reg;
  logic             pending;
  logic             delayed_edge;

  assign pending      = (sig_in != sig_out);
  assign delayed_edge = (kind == DELAY_RISING_EDGE) ? sig_in : !sig_in;

  // ---------------------------------------------------------------
  // Delay counter, restarted whenever input and output agree again
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      sig_out <= 1'b0;
    end else if (!pending) begin
      cnt_reg <= '0;
    end else if (!delayed_edge || delay_count == '0) begin
      sig_out <= sig_in;
      cnt_reg <= '0;
    end else if (step) begin
      if (cnt_reg >= delay_count - WIDTH'(1)) begin
        sig_out <= sig_in;
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + WIDTH'(1);
      end
    end
  end
endmodule

// >>> verif/deadband_chopper_path_chk.sv
// Bus answer and direct path checks at the top ports
`timescale 1ns/1ps
`include "deadband_chopper_params.svh"
module deadband_chopper_path_chk
  import deadband_chopper_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [7:0]  awaddr,
  input wire logic [2:0]  awprot,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0]  wstrb,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire deadband_chopper_pkg::axi_resp_t bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [7:0]  araddr,
  input wire logic [2:0]  arprot,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire deadband_chopper_pkg::axi_resp_t rresp,
  input wire logic        channel_a_in,
  input wire logic        channel_b_in,
  input wire logic        channel_a_out,
  input wire logic        channel_b_out
);
  logic [1:0] mode_reg;
  logic       chop_reg;
  logic [3:0] age_reg;
  logic       wr_hs;
  logic       quiet;
  logic       unmapped;
  assign wr_hs = awvalid && awready && wvalid && wready;
  assign quiet = age_reg > 4'h5;
  assign unmapped = !(araddr[7:2] inside {6'h0f, 6'h10, 6'h11, 6'h1e, 6'h20, 6'h21});
  // ----------------------------------------
  // Shadow of output mode and chopper enable
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= 2'b00;
    end else if (wr_hs && awaddr == 8'h3c) begin
      mode_reg <= wdata[1:0];
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chop_reg <= 1'b0;
    end else if (wr_hs && awaddr == 8'h78) begin
      chop_reg <= wdata[0];
    end
  end
  // Cycles since the last register write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      age_reg <= 4'h0;
    end else if (wr_hs) begin
      age_reg <= 4'h0;
    end else if (age_reg != 4'hf) begin
      age_reg <= age_reg + 4'h1;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before accepted");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before accepted");
  a_write_answer: assert property (wr_hs |-> ##[1:2] bvalid)
    else $error("write response late");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  a_unmapped_error: assert property (arvalid && arready && unmapped |=> rresp == `RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  a_ready_gap: assert property ($rose(bvalid) |-> !awready && !wready)
    else $error("write ready returned too soon");
  a_a_direct: assert property (quiet && !chop_reg && !mode_reg[1] |-> channel_a_out == $past(channel_a_in, 2))
    else $error("channel a not passed straight");
  a_b_direct: assert property (quiet && !chop_reg && !mode_reg[0] |-> channel_b_out == $past(channel_b_in, 2))
    else $error("channel b not passed straight");
  a_chop_gate: assert property (quiet && chop_reg && mode_reg == 2'b00 && channel_a_out |-> $past(channel_a_in, 2) || $past(channel_a_in, 3))
    else $error("chopped output outside dead-band pulse");
  c_write: cover property (wr_hs);
  c_unmapped: cover property (rvalid && rresp == `RESP_SLVERR);
  c_chop: cover property (quiet && chop_reg && channel_a_out);
endmodule
bind deadband_chopper_path deadband_chopper_path_chk chk_u (.*);

// >>> verif/qualifier_model.sv
// Upstream action-qualifier stand-in: two PWM waves from one counter
`timescale 1ns/1ps
module qualifier_model (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [9:0] period,
  input  wire logic [9:0] high,
  input  wire logic [9:0] shift,
  output logic            channel_a_in,
  output logic            channel_b_in
);
  logic [9:0] cnt_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 10'h000;
    end else if (cnt_reg >= period - 10'h001) begin
      cnt_reg <= 10'h000;
    end else begin
      cnt_reg <= cnt_reg + 10'h001;
    end
  end
  // Channel B is channel A moved later by shift clocks
  assign channel_a_in = cnt_reg < high;
  assign channel_b_in = (cnt_reg >= shift) && (cnt_reg < shift + high);
endmodule

// >>> verif/test_deadband_chopper_path.sv
// Self-checking bench of the dead-band and chopper path
`timescale 1ns/1ps
`include "deadband_chopper_params.svh"
module test_deadband_chopper_path;
  import deadband_chopper_pkg::*;
  logic        core_clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, channel_a_in, channel_b_in;
  logic        channel_a_out, channel_b_out;
  logic [7:0]  awaddr, araddr;
  logic [2:0]  awprot, arprot;
  logic [3:0]  wstrb, w;
  logic [31:0] wdata, rdata, rd, v;
  logic [9:0]  period, high, shift, r, f;
  axi_resp_t   bresp, rresp, rs;
  logic [31:0] seed = 32'h39360839;
  int          miscompares = 0, comparisons = 0, c, n, ca, cb;
  logic [5:0]  idx_t [5] = '{6'h0f, 6'h10, 6'h11, 6'h1e, 6'h20};
  logic [15:0] msk_t [5] = '{16'h803f, 16'h03ff, 16'h03ff, 16'h07ff, 16'h00ff};

  deadband_chopper_path dut_u (.*);
  qualifier_model model_u (.*);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic sig(int i);
    case (i)
      0: return channel_a_in;
      1: return channel_b_in;
      2: return channel_a_out;
      default: return channel_b_out;
    endcase
  endfunction
  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic fail_now(string m);
    $display("Error at %0t: %s", $time, m);
    miscompares++;
  endtask
  task automatic guard(bit ok, string m);
    if (!ok) begin
      fail_now(m);
      finish_test();
    end
  endtask
  task automatic check_val(logic [31:0] got, logic [31:0] exp, string m);
    comparisons++;
    if (got !== exp) fail_now(m);
  endtask
  task automatic check_rng(int got, int lo, int hi, string m);
    comparisons++;
    if (got < lo || got > hi) fail_now(m);
  endtask
  // ----------------------------------------
  // AXI4-Lite master
  // ----------------------------------------
  task automatic axi_write(logic [7:0] a, logic [31:0] d, output axi_resp_t rsp);
    bit ta, tw;
    ta = 0;
    tw = 0;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (!ta && awready) begin ta = 1; awvalid <= 1'b0; end
      if (!tw && wready) begin tw = 1; wvalid <= 1'b0; end
    end while (!(ta && tw) && n < 200);
    do begin @(posedge core_clk); n++; end while (bvalid !== 1'b1 && n < 400);
    guard(bvalid === 1'b1, "write timeout");
    rsp = bresp;
  endtask
  task automatic axi_read(logic [7:0] a, output logic [31:0] d, output axi_resp_t rsp);
    bit tk, got;
    tk = 0;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      got = tk && rvalid === 1'b1;
      if (!tk && arready) begin tk = 1; arvalid <= 1'b0; end
    end while (!got && n < 200);
    guard(got, "read timeout");
    d = rdata;
    rsp = rresp;
  endtask
  task automatic wr(logic [5:0] i, logic [31:0] d);
    axi_write({i, 2'b00}, d, rs);
    check_val({30'h0, rs}, {30'h0, `RESP_OKAY}, "write refused");
  endtask
  task automatic cfg(logic [7:0] div, logic [15:0] dt, logic [9:0] rr, logic [9:0] ff);
    wr(`IDX_TICK_DIVIDER, {24'h0, div});
    wr(`IDX_RISE_DELAY_COUNT, {22'h0, rr});
    wr(`IDX_FALL_DELAY_COUNT, {22'h0, ff});
    wr(`IDX_DEADTIME_CONTROL, {16'h0, dt});
  endtask
  // Clocks from an edge of input s until output d reaches level dl
  task automatic measure(int s, logic sl, int d, logic dl);
    n = 0;
    do begin @(posedge core_clk); n++; end while (sig(s) !== ~sl && n < 2000);
    do begin @(posedge core_clk); n++; end while (sig(s) !== sl && n < 2000);
    c = 0;
    do begin @(posedge core_clk); c++; end while (sig(d) !== dl && c < 2000);
    guard(c < 2000 && n < 2000, "edge wait timeout");
  endtask
  task automatic edge_chk(int s, logic sl, int d, logic dl, int cnt, int sp);
    measure(s, sl, d, dl);
    check_rng(c, (cnt == 0) ? 2 : (cnt - 1) * sp + 2, cnt * sp + 2, "edge delay");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h05;
    awaddr = 8'h00;
    araddr = 8'h00;
    awprot = 3'h0;
    arprot = 3'h0;
    wstrb = 4'hf;
    wdata = 32'h0;
    period = 10'd400;
    high = 10'd200;
    shift = 10'd50;
    rst_n = 1'b0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    foreach (idx_t[i]) begin
      axi_read({idx_t[i], 2'b00}, rd, rs);
      check_val(rd, 32'h0, "reset value");
      v = rnd();
      wr(idx_t[i], v);
      axi_read({idx_t[i], 2'b00}, rd, rs);
      check_val(rd, v & {16'h0, msk_t[i]}, "readback");
    end
    wr(`IDX_CHOPPER_CONTROL, 32'h0);
    wr(`IDX_PATH_STATUS, 32'hffff);
    axi_write(8'h48, 32'hffff, rs);
    check_val({30'h0, rs}, {30'h0, `RESP_SLVERR}, "unmapped write");
    axi_read(8'h48, rd, rs);
    check_val({30'h0, rs}, {30'h0, `RESP_SLVERR}, "unmapped read");
    check_val(rd, 32'h0, "unmapped data");
    for (int m = 0; m < 4; m++) begin
      r = 10'(rnd() % 30 + 1);
      f = 10'(rnd() % 30 + 1);
      cfg(8'h00, 16'((m == 0) ? 12 : m), r, f);
      if (m[1]) edge_chk(0, 1, 2, 1, r, 1);
      else edge_chk(0, 1, 2, 1, 0, 1);
      if (m[0]) edge_chk(0, 0, 3, 0, f, 1);
      else edge_chk(1, 1, 3, 1, 0, 1);
    end
    for (int k = 0; k < 4; k++) begin
      r = (k == 0) ? 10'd0 : 10'(rnd() % 40 + 1);
      f = (k == 3) ? 10'd90 : 10'(rnd() % 40 + 1);
      cfg({7'h0, k[0]}, {k[1], 11'h0, k[1:0], 2'b11}, r, f);
      edge_chk(0, 1, 2, !k[0], r, (k == 1) ? 2 : 1);
      edge_chk(0, 0, 3, k[1], f, (k == 1) ? 2 : 1);
      edge_chk(0, 1, 3, !k[1], 0, 1);
    end
    for (int j = 0; j < 4; j++) begin
      cfg(8'h00, 16'((j << 4) | 3), r, f);
      edge_chk(j[0], 1, 2, 1, r, 1);
      edge_chk(j[1], 0, 3, 0, f, 1);
    end
    high <= 10'd10;
    cfg(8'h00, 16'h0003, 10'd30, 10'd0);
    repeat (20) @(posedge core_clk);
    c = 0;
    repeat (800) begin @(posedge core_clk); c += int'(channel_a_out === 1'b1); end
    check_val(c, 0, "short pulse not suppressed");
    high <= 10'd400;
    period <= 10'd800;
    shift <= 10'd0;
    cfg(8'h00, 16'h0000, 10'd0, 10'd0);
    for (int d = 0; d < 7; d++) begin
      w = (d == 0) ? 4'hf : 4'(rnd());
      wr(`IDX_CHOPPER_CONTROL, {21'h0, 3'(d), 3'(d % 2), w, 1'b1});
      measure(0, 1, 2, 1);
      check_rng(c, 2, 3, "first pulse start");
      n = 0;
      do begin @(posedge core_clk); n++; end while (channel_a_out === 1'b1 && n < 300);
      check_rng(n, 8 * (w + 1), 8 * (w + 1) + (d + 1) * (d % 2 + 1), "first pulse");
      ca = 0;
      cb = 0;
      repeat (64) begin
        @(posedge core_clk);
        ca += int'(channel_a_out === 1'b1);
        cb += int'(channel_b_out === 1'b1);
      end
      check_val(ca, 8 * (d + 1), "carrier duty");
      check_val(cb, 8 * (d + 1), "second channel duty");
    end
    wr(`IDX_CHOPPER_CONTROL, 32'h0);
    edge_chk(0, 1, 2, 1, 0, 1);
    finish_test();
  end
endmodule
